//--- hdl/ocd_cycles.sv
// Cycle count lookup per class.
// Assumes block moves run long when the data operand is not on chip.
`timescale 1ns/1ps
module ocd_cycles (
    input  ocd_pkg::ocd_class_t  class_in,
    input  wire logic            long_move_in,
    input  wire logic            taken_in,
    output logic [2:0]           cycles_out
);
    always_comb begin
        unique case (class_in)
            ocd_pkg::OCD_BMDD_SRC, ocd_pkg::OCD_BMDD_DST,
            ocd_pkg::OCD_BMPD: begin
                cycles_out = long_move_in ? ocd_pkg::OCD_CYC_5
                                          : ocd_pkg::OCD_CYC_3;
            end
            ocd_pkg::OCD_PORT_IN, ocd_pkg::OCD_ACC_LONG: begin
                cycles_out = ocd_pkg::OCD_CYC_2;
            end
            ocd_pkg::OCD_BR_ACC_ZERO: begin
                cycles_out = taken_in ? ocd_pkg::OCD_CYC_4
                                      : ocd_pkg::OCD_CYC_2;
            end
            default: begin
                cycles_out = ocd_pkg::OCD_CYC_1;
            end
        endcase
    end
endmodule : ocd_cycles

//--- hdl/ocd_decoder.sv
// Opcode decoder for a subset of the core instruction set.
// Assumes the fetch path presents one word per valid pulse and
// that the datapath reports branch outcome with the first word.
//
// What this block does
// - Aux compare against aux_reg_zero, 1011 1111 0100 01xx, 1 word 1 cycle.
// - Data-data block move, source immediate, 0xa8 plus address; 3 or 5.
// - Data-data block move, destination immediate, 0xa9 plus address.
// - Program-to-data block move, 0xa5 plus address, second word prog addr.
// - Data move, high byte 0x77, one word one cycle.
// - Port input, 0xaf plus address, second word port address, 2 cycles.
// - Accumulator load with shift, top nibble 1, shift bits 11..8.
// - Long accumulator load, 0xbf8 plus shift, constant word, 2 cycles.
// - Zero low, load high accumulator, high byte 0x6a, one cycle.
// - Test bit by multiplicand_reg, high byte 0x6f, one cycle.
// - Branch if accumulator zero, exactly 0xe388, second word address, 4 taken, 2 not.
// - Configure dual-access block as data, 0xbe44, one cycle.
`timescale 1ns/1ps
module ocd_decoder (
    input  wire logic                clk_sys_in,
    input  wire logic                rst_n_in,
    input  wire logic                word_valid_in,
    input  wire logic [15:0]         word_in,
    input  wire logic                branch_taken_in,
    input  wire logic                long_move_in,
    output ocd_pkg::ocd_class_t      class_out,
    output logic                     dec_valid_out,
    output logic [1:0]               words_out,
    output logic [2:0]               cycles_out,
    output logic [7:0]               addr_field_out,
    output logic [3:0]               shift_out,
    output logic [1:0]               cond_out,
    output logic [15:0]              second_word_out,
    output logic                     fetch_second_out
);

    // ------------------------------------------------------------
    // Pattern match and cycle lookup
    // ------------------------------------------------------------
    ocd_pkg::ocd_class_t  match_class;
    logic                 match_two;
    logic [2:0]           match_cycles;

    ocd_match u_match (
        .word_in      (word_in),
        .class_out    (match_class),
        .two_word_out (match_two)
    );

    ocd_cycles u_cycles (
        .class_in     (match_class),
        .long_move_in (long_move_in),
        .taken_in     (branch_taken_in),
        .cycles_out   (match_cycles)
    );

    // ------------------------------------------------------------
    // Sequencer and output registers
    // ------------------------------------------------------------
    // Two-word ops hold the first word's fields until the second word
    // arrives, so the datapath sees one complete decode at a time.
    ocd_pkg::ocd_state_t  state_r, state_nxt;
    ocd_pkg::ocd_class_t  class_r, class_nxt;
    logic                 valid_r, valid_nxt;
    logic [1:0]           words_r, words_nxt;
    logic [2:0]           cycles_r, cycles_nxt;
    logic [7:0]           addr_r, addr_nxt;
    logic [3:0]           shift_r, shift_nxt;
    logic [1:0]           cond_r, cond_nxt;
    logic [15:0]          second_r, second_nxt;
    logic                 fetch_r, fetch_nxt;

    always_comb begin
        state_nxt  = state_r;
        class_nxt  = class_r;
        valid_nxt  = 1'b0;
        words_nxt  = words_r;
        cycles_nxt = cycles_r;
        addr_nxt   = addr_r;
        shift_nxt  = shift_r;
        cond_nxt   = cond_r;
        second_nxt = second_r;
        fetch_nxt  = 1'b0;
        unique case (state_r)
            ocd_pkg::OCD_ST_FIRST: begin
                if (word_valid_in) begin
                    class_nxt  = match_class;
                    cycles_nxt = match_cycles;
                    addr_nxt   = word_in[7:0];
                    second_nxt = 16'h0000;
                    shift_nxt  = 4'h0;
                    cond_nxt   = 2'h0;
                    if (match_class == ocd_pkg::OCD_ACC_SHIFT) begin
                        shift_nxt = word_in[ocd_pkg::OCD_SHIFT_LSB +: 4];
                    end
                    if (match_class == ocd_pkg::OCD_ACC_LONG) begin
                        shift_nxt = word_in[3:0];
                    end
                    if (match_class == ocd_pkg::OCD_AUX_COMPARE) begin
                        cond_nxt = word_in[ocd_pkg::OCD_COND_LSB +: 2];
                    end
                    if (match_two) begin
                        words_nxt = ocd_pkg::OCD_WORDS_2;
                        fetch_nxt = 1'b1;
                        state_nxt = ocd_pkg::OCD_ST_SECOND;
                    end else begin
                        words_nxt = ocd_pkg::OCD_WORDS_1;
                        valid_nxt = 1'b1;
                    end
                end
            end
            ocd_pkg::OCD_ST_SECOND: begin
                if (word_valid_in) begin
                    second_nxt = word_in;
                    valid_nxt  = 1'b1;
                    state_nxt  = ocd_pkg::OCD_ST_FIRST;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_r  <= ocd_pkg::OCD_ST_FIRST;
            class_r  <= ocd_pkg::OCD_NONE;
            valid_r  <= 1'b0;
            words_r  <= 2'h0;
            cycles_r <= 3'h0;
            addr_r   <= 8'h00;
            shift_r  <= 4'h0;
            cond_r   <= 2'h0;
            second_r <= 16'h0000;
            fetch_r  <= 1'b0;
        end else begin
            state_r  <= state_nxt;
            class_r  <= class_nxt;
            valid_r  <= valid_nxt;
            words_r  <= words_nxt;
            cycles_r <= cycles_nxt;
            addr_r   <= addr_nxt;
            shift_r  <= shift_nxt;
            cond_r   <= cond_nxt;
            second_r <= second_nxt;
            fetch_r  <= fetch_nxt;
        end
    end

    assign class_out        = class_r;
    assign dec_valid_out    = valid_r;
    assign words_out        = words_r;
    assign cycles_out       = cycles_r;
    assign addr_field_out   = addr_r;
    assign shift_out        = shift_r;
    assign cond_out         = cond_r;
    assign second_word_out  = second_r;
    assign fetch_second_out = fetch_r;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // Block moves onto mask/flag regs are software's concern; not checked.
    sequence s_first_two;
        word_valid_in && state_r == ocd_pkg::OCD_ST_FIRST && match_two;
    endsequence

    sequence s_second_now;
        word_valid_in && state_r == ocd_pkg::OCD_ST_SECOND;
    endsequence

    chk_aux_cmp_cond: assert property (
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        (word_valid_in && state_r == ocd_pkg::OCD_ST_FIRST
         && word_in[15:2] == 14'h2fd1)
        |=> (class_out == ocd_pkg::OCD_AUX_COMPARE && dec_valid_out
             && cond_out == $past(word_in[1:0]) && cycles_out == 3'h1))
        else $error("aux compare decode wrong");

    chk_bmdd_src_cyc: assert property (
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        (s_first_two and (word_in[15:8] == 8'ha8))
        |=> (class_out == ocd_pkg::OCD_BMDD_SRC
             && cycles_out == ($past(long_move_in) ? 3'h5 : 3'h3)))
        else $error("source block move cycles wrong");

    chk_bmdd_dst_two: assert property (
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        (s_first_two and (word_in[15:8] == 8'ha9))
        |=> (class_out == ocd_pkg::OCD_BMDD_DST && words_out == 2'h2))
        else $error("dest block move words wrong");

    chk_bmpd_addr: assert property (
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        (s_first_two and (word_in[15:8] == 8'ha5))
        |=> (class_out == ocd_pkg::OCD_BMPD
             && addr_field_out == $past(word_in[7:0])))
        else $error("prog block move addr wrong");

    chk_data_move_one: assert property (
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        (word_valid_in && state_r == ocd_pkg::OCD_ST_FIRST
         && word_in[15:8] == 8'h77)
        |=> (dec_valid_out && words_out == 2'h1 && !fetch_second_out))
        else $error("data move decode wrong");

    chk_port_in_seq: assert property (
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        (s_first_two and (word_in[15:8] == 8'haf))
        ##1 word_valid_in
        |=> (dec_valid_out && cycles_out == 3'h2
             && second_word_out == $past(word_in)))
        else $error("port input second word wrong");

    chk_acc_shift: assert property (
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        (word_valid_in && state_r == ocd_pkg::OCD_ST_FIRST
         && word_in[15:12] == 4'h1)
        |=> (class_out == ocd_pkg::OCD_ACC_SHIFT
             && shift_out == $past(word_in[11:8])))
        else $error("acc shift field wrong");

    chk_fetch_second: assert property (
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        s_first_two |=> (fetch_second_out && !dec_valid_out))
        else $error("second fetch not requested");

    chk_dst_cycles: assert property (
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        (s_first_two and (word_in[15:8] == 8'ha9))
        |=> (cycles_out == ($past(long_move_in) ? 3'h5 : 3'h3)))
        else $error("dest block move cycles wrong");

    chk_bmpd_cycles: assert property (
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        (s_first_two and (word_in[15:8] == 8'ha5))
        |=> (words_out == 2'h2
             && cycles_out == ($past(long_move_in) ? 3'h5 : 3'h3)))
        else $error("prog block move cycles wrong");

    chk_acc_long_fields: assert property (
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        (s_first_two and (word_in[15:4] == 12'hbf8))
        |=> (class_out == ocd_pkg::OCD_ACC_LONG && cycles_out == 3'h2
             && shift_out == $past(word_in[3:0])))
        else $error("long acc load fields wrong");

    chk_zlh_one_word: assert property (
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        (word_valid_in && state_r == ocd_pkg::OCD_ST_FIRST
         && word_in[15:8] == 8'h6a)
        |=> (class_out == ocd_pkg::OCD_ACC_ZLH && dec_valid_out
             && cycles_out == 3'h1))
        else $error("zero-low load decode wrong");

    chk_tbit_one_word: assert property (
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        (word_valid_in && state_r == ocd_pkg::OCD_ST_FIRST
         && word_in[15:8] == 8'h6f)
        |=> (class_out == ocd_pkg::OCD_TEST_BIT && dec_valid_out
             && cycles_out == 3'h1))
        else $error("bit test decode wrong");

    chk_cfg_one_word: assert property (
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        (word_valid_in && state_r == ocd_pkg::OCD_ST_FIRST
         && word_in == 16'hbe44)
        |=> (class_out == ocd_pkg::OCD_CFG_DATA && dec_valid_out
             && words_out == 2'h1 && cycles_out == 3'h1))
        else $error("block config decode wrong");

    chk_br_zero_cyc: assert property (
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        (s_first_two and (word_in == 16'he388))
        |=> (class_out == ocd_pkg::OCD_BR_ACC_ZERO
             && cycles_out == ($past(branch_taken_in) ? 3'h4 : 3'h2)))
        else $error("branch if zero cycles wrong");

    chk_second_taken: assert property (
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        s_second_now
        |=> (dec_valid_out && !fetch_second_out
             && second_word_out == $past(word_in)
             && state_r == ocd_pkg::OCD_ST_FIRST))
        else $error("second word not taken");

    chk_one_word_done: assert property (
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        (word_valid_in && state_r == ocd_pkg::OCD_ST_FIRST && !match_two)
        |=> (dec_valid_out && !fetch_second_out && words_out == 2'h1
             && second_word_out == 16'h0000))
        else $error("one word decode incomplete");

    chk_idle_quiet: assert property (
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        !word_valid_in |=> (!dec_valid_out && !fetch_second_out))
        else $error("pulse without a word");

    // Slow fetch must not disturb the first word's fields
    chk_fields_held: assert property (
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        (state_r == ocd_pkg::OCD_ST_SECOND && !word_valid_in)
        |=> ($stable(class_out) && $stable(addr_field_out)
             && $stable(cycles_out) && state_r == ocd_pkg::OCD_ST_SECOND))
        else $error("fields moved while waiting");

endmodule : ocd_decoder

//--- hdl/ocd_match.sv
// Combinational pattern match of one first instruction word.
// Assumes the word is stable for the cycle it is presented.
`timescale 1ns/1ps
module ocd_match (
    input  wire logic [15:0]         word_in,
    output ocd_pkg::ocd_class_t      class_out,
    output logic                     two_word_out
);
    always_comb begin
        class_out = ocd_pkg::OCD_NONE;
        if (word_in[15:2] == ocd_pkg::OCD_AUX_CMP_PAT) begin
            class_out = ocd_pkg::OCD_AUX_COMPARE;
        end else if (word_in == ocd_pkg::OCD_BR_ZERO_OP) begin
            class_out = ocd_pkg::OCD_BR_ACC_ZERO;
        end else if (word_in == ocd_pkg::OCD_CFG_DATA_OP) begin
            class_out = ocd_pkg::OCD_CFG_DATA;
        end else if (word_in[15:4] == ocd_pkg::OCD_ACC_LONG_HI) begin
            class_out = ocd_pkg::OCD_ACC_LONG;
        end else if (word_in[15:8] == ocd_pkg::OCD_BMDD_SRC_HI) begin
            class_out = ocd_pkg::OCD_BMDD_SRC;
        end else if (word_in[15:8] == ocd_pkg::OCD_BMDD_DST_HI) begin
            class_out = ocd_pkg::OCD_BMDD_DST;
        end else if (word_in[15:8] == ocd_pkg::OCD_BMPD_HI) begin
            class_out = ocd_pkg::OCD_BMPD;
        end else if (word_in[15:8] == ocd_pkg::OCD_DATA_MOVE_HI) begin
            class_out = ocd_pkg::OCD_DATA_MOVE;
        end else if (word_in[15:8] == ocd_pkg::OCD_PORT_IN_HI) begin
            class_out = ocd_pkg::OCD_PORT_IN;
        end else if (word_in[15:8] == ocd_pkg::OCD_ACC_ZLH_HI) begin
            class_out = ocd_pkg::OCD_ACC_ZLH;
        end else if (word_in[15:8] == ocd_pkg::OCD_TBIT_HI) begin
            class_out = ocd_pkg::OCD_TEST_BIT;
        end else if (word_in[15:12] == ocd_pkg::OCD_ACC_SH_TOP) begin
            class_out = ocd_pkg::OCD_ACC_SHIFT;
        end
    end

    always_comb begin
        unique case (class_out)
            ocd_pkg::OCD_BMDD_SRC, ocd_pkg::OCD_BMDD_DST,
            ocd_pkg::OCD_BMPD, ocd_pkg::OCD_PORT_IN,
            ocd_pkg::OCD_ACC_LONG, ocd_pkg::OCD_BR_ACC_ZERO: begin
                two_word_out = 1'b1;
            end
            default: begin
                two_word_out = 1'b0;
            end
        endcase
    end
endmodule : ocd_match

//--- hdl/ocd_pkg.sv
// Opcode patterns, field positions and cycle counts for the decoder.
// Assumes 16-bit instruction words delivered by the fetch path.
package ocd_pkg;

    // ------------------------------------------------------------
    // Instruction classes
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        OCD_NONE        = 4'h0,
        OCD_AUX_COMPARE = 4'h1,
        OCD_BMDD_SRC    = 4'h2,
        OCD_BMDD_DST    = 4'h3,
        OCD_BMPD        = 4'h4,
        OCD_DATA_MOVE   = 4'h5,
        OCD_PORT_IN     = 4'h6,
        OCD_ACC_SHIFT   = 4'h7,
        OCD_ACC_LONG    = 4'h8,
        OCD_ACC_ZLH     = 4'h9,
        OCD_TEST_BIT    = 4'ha,
        OCD_BR_ACC_ZERO = 4'hb,
        OCD_CFG_DATA    = 4'hc
    } ocd_class_t;

    // Sequencer states
    typedef enum logic [0:0] {
        OCD_ST_FIRST  = 1'b0,
        OCD_ST_SECOND = 1'b1
    } ocd_state_t;

    // ------------------------------------------------------------
    // Patterns
    // ------------------------------------------------------------
    localparam logic [13:0] OCD_AUX_CMP_PAT = 14'h2fd1;
    localparam logic [7:0]  OCD_BMDD_SRC_HI = 8'ha8;
    localparam logic [7:0]  OCD_BMDD_DST_HI = 8'ha9;
    localparam logic [7:0]  OCD_BMPD_HI     = 8'ha5;
    localparam logic [7:0]  OCD_DATA_MOVE_HI     = 8'h77;
    localparam logic [7:0]  OCD_PORT_IN_HI  = 8'haf;
    localparam logic [3:0]  OCD_ACC_SH_TOP  = 4'h1;
    localparam logic [11:0] OCD_ACC_LONG_HI = 12'hbf8;
    localparam logic [7:0]  OCD_ACC_ZLH_HI  = 8'h6a;
    localparam logic [7:0]  OCD_TBIT_HI     = 8'h6f;
    localparam logic [15:0] OCD_BR_ZERO_OP  = 16'he388;
    localparam logic [15:0] OCD_CFG_DATA_OP = 16'hbe44;

    // ------------------------------------------------------------
    // Field positions and counts
    // ------------------------------------------------------------
    localparam int          OCD_SHIFT_LSB = 8;
    localparam int          OCD_COND_LSB  = 0;
    localparam logic [1:0]  OCD_WORDS_1   = 2'h1;
    localparam logic [1:0]  OCD_WORDS_2   = 2'h2;
    localparam logic [2:0]  OCD_CYC_1     = 3'h1;
    localparam logic [2:0]  OCD_CYC_2     = 3'h2;
    localparam logic [2:0]  OCD_CYC_3     = 3'h3;
    localparam logic [2:0]  OCD_CYC_4     = 3'h4;
    localparam logic [2:0]  OCD_CYC_5     = 3'h5;

endpackage : ocd_pkg

//--- testbench/ocd_fetch_model.sv
// Fetch-path model: presents first and second instruction words.
// Assumes the bench raises start_in for one cycle per instruction.
`timescale 1ns/1ps
module ocd_fetch_model (
    input  wire logic        clk_in,
    input  wire logic        start_in,
    input  wire logic [15:0] first_in,
    input  wire logic [15:0] second_in,
    input  wire logic        taken_in,
    input  wire logic        long_in,
    input  wire logic [3:0]  gap_in,
    input  wire logic        fetch_second_in,
    output logic             word_valid_out,
    output logic [15:0]      word_out,
    output logic             taken_out,
    output logic             long_out
);
    // ------------------------------------------------------------
    // Word sequencer
    // ------------------------------------------------------------
    initial begin
        word_valid_out = 1'b0;
        word_out       = 16'h0000;
        taken_out      = 1'b0;
        long_out       = 1'b0;
        forever begin
            @(posedge clk_in);
            if (start_in) begin
                @(negedge clk_in);
                word_valid_out = 1'b1;
                word_out       = first_in;
                taken_out      = taken_in;
                long_out       = long_in;
                @(negedge clk_in);
                taken_out      = ~taken_out;
                long_out       = ~long_out;
                if (fetch_second_in) begin
                    // Slow fetch: second word may lag by gap_in cycles
                    repeat (gap_in) begin
                        word_valid_out = 1'b0;
                        word_out       = ~first_in;
                        @(negedge clk_in);
                    end
                    word_valid_out = 1'b1;
                    word_out       = second_in;
                    @(negedge clk_in);
                end
                // Released lines toggle so stale values never look valid
                word_valid_out = 1'b0;
                word_out       = ~word_out;
            end
        end
    end
endmodule : ocd_fetch_model

//--- testbench/tb_dsp_core_opcode_decode_subset.sv
// Self-checking bench for the opcode decoder subset.
// Assumes ocd_pkg, the decoder and the fetch model are compiled first.
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_errors++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module tb_dsp_core_opcode_decode_subset;
    logic                clk_sys_in = 1'b0;
    logic                rst_n_in   = 1'b0;
    logic                start      = 1'b0;
    logic [15:0]         w_first    = 16'h0000;
    logic [15:0]         w_second   = 16'h0000;
    logic                tk_r       = 1'b0;
    logic                lg_r       = 1'b0;
    logic [3:0]          gap_r      = 4'h0;
    logic                word_valid, taken, longm, dec_valid, fetch2;
    logic [15:0]         word, second_word;
    logic [1:0]          words, cond;
    logic [2:0]          cycles;
    logic [7:0]          addr;
    logic [3:0]          shift;
    ocd_pkg::ocd_class_t cls;
    int                  n_errors   = 0;
    int                  cmp_count  = 0;

    always #5 clk_sys_in = ~clk_sys_in;

    ocd_fetch_model fetch (.clk_in(clk_sys_in), .start_in(start),
        .first_in(w_first), .second_in(w_second), .taken_in(tk_r),
        .long_in(lg_r), .gap_in(gap_r), .fetch_second_in(fetch2),
        .word_valid_out(word_valid), .word_out(word), .taken_out(taken),
        .long_out(longm));

    ocd_decoder dut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
        .word_valid_in(word_valid), .word_in(word),
        .branch_taken_in(taken), .long_move_in(longm), .class_out(cls),
        .dec_valid_out(dec_valid), .words_out(words), .cycles_out(cycles),
        .addr_field_out(addr), .shift_out(shift), .cond_out(cond),
        .second_word_out(second_word), .fetch_second_out(fetch2));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic complete_run;
        $display("counts: compares=%0d mismatches=%0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : complete_run

    task automatic run_op(input logic [15:0] w1, input logic [15:0] w2,
        input logic tk, input logic lg, input ocd_pkg::ocd_class_t cl,
        input logic [1:0] wd, input logic [2:0] cy, input logic [3:0] sh,
        input logic [1:0] cd, input int gap);
        int n;
        int fs;
        int lat;
        fs       = 0;
        lat      = (wd == ocd_pkg::OCD_WORDS_2) ? 3 + gap : 2;
        start    = 1'b1;
        w_first  = w1;
        w_second = w2;
        tk_r     = tk;
        lg_r     = lg;
        gap_r    = 4'(gap);
        for (n = 1; n <= 20; n++) begin
            @(negedge clk_sys_in);
            start = 1'b0;
            if (fetch2 === 1'b1) fs++;
            if (dec_valid === 1'b1) break;
        end
        if (n > 20) begin
            n_errors++;
            complete_run();
        end
        `CHK(n, lat)
        `CHK(fs, (wd == ocd_pkg::OCD_WORDS_2) ? 1 : 0)
        `CHK(cls, cl)
        `CHK(words, wd)
        `CHK(cycles, cy)
        `CHK(addr, w1[7:0])
        `CHK(shift, sh)
        `CHK(cond, cd)
        `CHK(second_word, (wd == ocd_pkg::OCD_WORDS_2) ? w2 : 16'h0000)
    endtask : run_op

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        repeat (20) @(negedge clk_sys_in);
        rst_n_in = 1'b1;
        @(negedge clk_sys_in);
        `CHK(dec_valid, 1'b0)
        `CHK(fetch2, 1'b0)
        `CHK(cls, ocd_pkg::OCD_NONE)
        $display("test reset done");
    endtask : t_reset

    task automatic t_one_word;
        for (int c = 0; c < 4; c++) begin
            run_op(16'hbf44 + 16'(c), 16'h0, 1'b0, 1'b0,
                ocd_pkg::OCD_AUX_COMPARE, 2'h1, 3'h1, 4'h0, 2'(c), 0);
        end
        run_op(16'h7712, 16'h0, 1'b0, 1'b0, ocd_pkg::OCD_DATA_MOVE,
            2'h1, 3'h1, 4'h0, 2'h0, 0);
        run_op(16'h1f8a, 16'h0, 1'b0, 1'b0, ocd_pkg::OCD_ACC_SHIFT,
            2'h1, 3'h1, 4'hf, 2'h0, 0);
        run_op(16'h1081, 16'h0, 1'b0, 1'b0, ocd_pkg::OCD_ACC_SHIFT,
            2'h1, 3'h1, 4'h0, 2'h0, 0);
        run_op(16'h6a33, 16'h0, 1'b0, 1'b0, ocd_pkg::OCD_ACC_ZLH,
            2'h1, 3'h1, 4'h0, 2'h0, 0);
        run_op(16'h6f90, 16'h0, 1'b0, 1'b0, ocd_pkg::OCD_TEST_BIT,
            2'h1, 3'h1, 4'h0, 2'h0, 0);
        run_op(16'hbe44, 16'h0, 1'b0, 1'b0, ocd_pkg::OCD_CFG_DATA,
            2'h1, 3'h1, 4'h0, 2'h0, 0);
        $display("test one_word done");
    endtask : t_one_word

    task automatic t_two_word;
        // Operand bytes kept off the interrupt and global regs
        run_op(16'ha860, 16'h0300, 1'b0, 1'b0, ocd_pkg::OCD_BMDD_SRC,
            2'h2, 3'h3, 4'h0, 2'h0, 0);
        run_op(16'ha8ff, 16'h0301, 1'b0, 1'b1, ocd_pkg::OCD_BMDD_SRC,
            2'h2, 3'h5, 4'h0, 2'h0, 3);
        run_op(16'ha961, 16'h0302, 1'b0, 1'b0, ocd_pkg::OCD_BMDD_DST,
            2'h2, 3'h3, 4'h0, 2'h0, 0);
        run_op(16'ha962, 16'h0303, 1'b0, 1'b1, ocd_pkg::OCD_BMDD_DST,
            2'h2, 3'h5, 4'h0, 2'h0, 1);
        run_op(16'ha570, 16'hf000, 1'b0, 1'b0, ocd_pkg::OCD_BMPD,
            2'h2, 3'h3, 4'h0, 2'h0, 0);
        run_op(16'ha571, 16'hf001, 1'b0, 1'b1, ocd_pkg::OCD_BMPD,
            2'h2, 3'h5, 4'h0, 2'h0, 2);
        run_op(16'haf05, 16'h1234, 1'b0, 1'b1, ocd_pkg::OCD_PORT_IN,
            2'h2, 3'h2, 4'h0, 2'h0, 0);
        run_op(16'hbf8c, 16'h8001, 1'b0, 1'b0, ocd_pkg::OCD_ACC_LONG,
            2'h2, 3'h2, 4'hc, 2'h0, 4);
        run_op(16'he388, 16'h4000, 1'b1, 1'b0, ocd_pkg::OCD_BR_ACC_ZERO,
            2'h2, 3'h4, 4'h0, 2'h0, 0);
        run_op(16'he388, 16'h4001, 1'b0, 1'b0, ocd_pkg::OCD_BR_ACC_ZERO,
            2'h2, 3'h2, 4'h0, 2'h0, 2);
        $display("test two_word done");
    endtask : t_two_word

    task automatic t_near_miss;
        // Neighbouring encodings must fall through to no class
        logic [15:0] ops [4] = '{16'hbf40, 16'he308, 16'hbe40, 16'h0000};
        foreach (ops[i]) begin
            run_op(ops[i], 16'h0, 1'b1, 1'b1, ocd_pkg::OCD_NONE,
                2'h1, 3'h1, 4'h0, 2'h0, 0);
        end
        $display("test near_miss done");
    endtask : t_near_miss

    initial begin
        t_reset();
        t_one_word();
        t_two_word();
        t_near_miss();
        complete_run();
    end
endmodule : tb_dsp_core_opcode_decode_subset
